//--- hw/spimsp_pkg.sv
package spimsp_pkg;
   // Register byte addresses (one 32-bit word each)
   localparam logic [3:0] SPIMSP_OFS_CTRL = 4'h0;
   localparam logic [3:0] SPIMSP_OFS_STAT = 4'h4;
   localparam logic [3:0] SPIMSP_OFS_DATA = 4'h8;
   // Control register fields
   localparam int SPIMSP_C_IRQEN  = 7;
   localparam int SPIMSP_C_EN     = 6;
   localparam int SPIMSP_C_LSBF   = 5;
   localparam int SPIMSP_C_MASTER_SELECT_BIT   = 4;
   localparam int SPIMSP_C_CLOCK_IDLE_LEVEL   = 3;
   localparam int SPIMSP_C_CLOCK_SAMPLE_PHASE   = 2;
   localparam int SPIMSP_C_RATEHI = 1;
   localparam int SPIMSP_C_RATELO = 0;
   // Status register fields
   localparam int SPIMSP_S_DONE   = 7;
   localparam int SPIMSP_S_CLASH  = 6;
   localparam int SPIMSP_S_DBL    = 0;
   // Reset values
   localparam logic [7:0] SPIMSP_CTRL_RST = 8'h00;
   localparam logic [7:0] SPIMSP_DATA_RST = 8'h00;
   // Byte shape
   localparam int         SPIMSP_BITS      = 8;
   localparam logic [3:0] SPIMSP_LAST_EDGE = 4'hF;
   localparam logic [3:0] SPIMSP_BYTE_CNT  = 4'h8;
   // Half SCK periods in system clocks, normal rate (/4,/16,/64,/128)
   localparam logic [6:0] SPIMSP_HALF_N0 = 7'h02;
   localparam logic [6:0] SPIMSP_HALF_N1 = 7'h08;
   localparam logic [6:0] SPIMSP_HALF_N2 = 7'h20;
   localparam logic [6:0] SPIMSP_HALF_N3 = 7'h40;
   // Half SCK periods, double rate (/2,/8,/32,/64)
   localparam logic [6:0] SPIMSP_HALF_D0 = 7'h01;
   localparam logic [6:0] SPIMSP_HALF_D1 = 7'h04;
   localparam logic [6:0] SPIMSP_HALF_D2 = 7'h10;
   localparam logic [6:0] SPIMSP_HALF_D3 = 7'h20;

   typedef enum logic {SPIMSP_IDLE, SPIMSP_XFER} spimsp_state_e;
endpackage

//--- hw/spimsp_top.sv
`timescale 1ns/100ps
// What this block does
// [R1] Slave: select always input; low activates, MISO drives only if enabled.
// [R2] Slave: select high resets bit counter and drops partial byte.
// [R3] Master with select as output: pin is plain output, no effect.
// [R4] Master with select input driven low: clear master bit, become slave.
// [R5] That event also sets the done flag, raising interrupt if enabled.
// [R6] Software must set master bit again after demotion.
// [R7] Data driven on one SCK edge, sampled on the opposite edge.
// [R8] Four modes from idle level and phase select sample edges.
// [R9] Idle level one rests SCK high; zero rests it low.
// [R10] Phase zero samples leading edge; phase one samples trailing edge.
// [R11] Bit order one sends LSB first; zero sends MSB first.
// [R12] Nothing happens unless the port enable bit is set.
// [R13] Interrupt when done flag, done enable and global enable all set.
// [R14] Master SCK divisors 4,16,64,128 or 2,8,32,64 with double rate.
// [R15] Rate bits have no effect in slave mode.
// [R16] Done flag set when a byte transfer completes.
// [R17] Done clears on vector, or status read then data access.
// [R18] Data write while busy sets clash flag; cleared by status read then data access.
// [R19] Status bits 5 to 1 read as zero.
// [R20] Double rate gives shortest master SCK period of two clocks.
// [R21] External master keeps SCK at or below a quarter system clock.
// [R22] Data write starts a byte; data read returns receive buffer.
// [R23] Master shifts exactly eight bits, then stops and sets done.
// [R24] Transmit single buffered; receive buffer overwritten by next byte.
// [R25] External master keeps each SCK phase over two system clocks.
// [R26] Write during transfer leaves shift register and byte untouched.
module spimsp_top
   import spimsp_pkg::*;
(
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   // Avalon-MM slave
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Pin direction choices and global interrupt enable
   input  wire logic        i_sck_dir,
   input  wire logic        i_mosi_dir,
   input  wire logic        i_miso_dir,
   input  wire logic        i_ss_dir,
   input  wire logic        i_ss_gpo,
   input  wire logic        i_global_irq_en,
   input  wire logic        i_irq_vector_ack,
   output logic             o_irq,
   // SPI pins
   input  wire logic        i_sck_i,
   output logic             o_sck_o,
   output logic             o_sck_oe,
   input  wire logic        i_mosi_i,
   output logic             o_mosi_o,
   output logic             o_mosi_oe,
   input  wire logic        i_miso_i,
   output logic             o_miso_o,
   output logic             o_miso_oe,
   input  wire logic        i_ss_i,
   output logic             o_ss_o,
   output logic             o_ss_oe
);

   typedef struct packed {
      logic          waitreq;
      logic [31:0]   rdata;
      logic [7:0]    ctrl;
      logic          dbl;
      logic          done;
      logic          clash;
      logic          arm;
      logic [7:0]    shreg;
      logic [7:0]    rxbuf;
      logic          tx;
      logic [3:0]    bitcnt;
      logic [3:0]    edge_idx;
      logic [6:0]    divcnt;
      spimsp_state_e state;
      logic          sck;
      logic          sck_prev;
      logic          sck_oe;
      logic          mosi_oe;
      logic          miso_oe;
      logic          ss_o;
      logic          ss_oe;
      logic          irq;
   } spimsp_regs_s;

   spimsp_regs_s q;
   spimsp_regs_s d;

   // [R14] divisor table
   function automatic logic [6:0] half_period(input logic dbl,
                                              input logic [1:0] rate);
      logic [6:0] h;
      h = SPIMSP_HALF_N0;
      case ({dbl, rate})
         3'b000: h = SPIMSP_HALF_N0;
         3'b001: h = SPIMSP_HALF_N1;
         3'b010: h = SPIMSP_HALF_N2;
         3'b011: h = SPIMSP_HALF_N3;
         3'b100: h = SPIMSP_HALF_D0;
         3'b101: h = SPIMSP_HALF_D1;
         3'b110: h = SPIMSP_HALF_D2;
         default: h = SPIMSP_HALF_D3;
      endcase
      return h;
   endfunction

   // [R11] outgoing bit position
   function automatic logic out_bit(input logic lsbf, input logic [7:0] s);
      return lsbf ? s[0] : s[SPIMSP_BITS-1];
   endfunction

   function automatic logic [7:0] shift_in(input logic lsbf,
                                           input logic [7:0] s,
                                           input logic b);
      return lsbf ? {b, s[7:1]} : {s[6:0], b};
   endfunction

   logic       en;
   logic       master_select_bit;
   logic       lsbf;
   logic       clock_idle_level;
   logic       clock_sample_phase;
   logic       req;
   logic       acc;
   logic       busy;
   logic       mode_fault;
   logic       sck_rise;
   logic       sck_fall;
   logic       lead;
   logic       trail;
   logic       s_sample;
   logic       s_setup;
   logic       slave_on;
   logic [6:0] half;

   always_comb begin
      d          = q;
      en         = q.ctrl[SPIMSP_C_EN];
      master_select_bit       = q.ctrl[SPIMSP_C_MASTER_SELECT_BIT];
      lsbf       = q.ctrl[SPIMSP_C_LSBF];
      clock_idle_level       = q.ctrl[SPIMSP_C_CLOCK_IDLE_LEVEL];
      clock_sample_phase       = q.ctrl[SPIMSP_C_CLOCK_SAMPLE_PHASE];
      half       = half_period(q.dbl,
                               q.ctrl[SPIMSP_C_RATEHI:SPIMSP_C_RATELO]);
      req        = i_avs_read | i_avs_write;
      // Request completes on the edge where waitrequest is seen low
      acc        = req & ~q.waitreq;
      busy       = (q.state == SPIMSP_XFER) | (q.bitcnt != 4'h0);
      // [R4] select input pulled low while master
      mode_fault = en & master_select_bit & ~i_ss_dir & ~i_ss_i;
      // Pins are synchronous, so one stage is enough for edge finding
      sck_rise   = i_sck_i & ~q.sck_prev;
      sck_fall   = ~i_sck_i & q.sck_prev;
      // [R8] [R9] leading edge direction follows idle level
      lead       = clock_idle_level ? sck_fall : sck_rise;
      trail      = clock_idle_level ? sck_rise : sck_fall;
      // [R1] slave active only while select is low
      slave_on   = en & ~master_select_bit & ~i_ss_i;
      // [R10] [R7] sample and setup on opposite edges
      s_sample   = slave_on & (clock_sample_phase ? trail : lead);
      s_setup    = slave_on & (clock_sample_phase ? lead : trail);

      d.sck_prev = i_sck_i;

      // Bus handshake: one wait cycle per access
      d.waitreq = ~(req & q.waitreq);
      if (req & q.waitreq) begin
         d.rdata = 32'h0000_0000;
         case (i_avs_address)
            SPIMSP_OFS_CTRL: d.rdata[7:0] = q.ctrl;
            // [R19] reserved status bits zero
            SPIMSP_OFS_STAT: begin
               d.rdata[SPIMSP_S_DONE]  = q.done;
               d.rdata[SPIMSP_S_CLASH] = q.clash;
               d.rdata[SPIMSP_S_DBL]   = q.dbl;
            end
            // [R22] read returns receive buffer
            SPIMSP_OFS_DATA: d.rdata[7:0] = q.rxbuf;
            default: d.rdata = 32'h0000_0000;
         endcase
      end

      // [R17] [R18] status read arms, data access clears
      if (acc & i_avs_read & (i_avs_address == SPIMSP_OFS_STAT)
          & (q.done | q.clash)) begin
         d.arm = 1'b1;
      end
      if (acc & (i_avs_address == SPIMSP_OFS_DATA) & q.arm) begin
         d.arm   = 1'b0;
         d.done  = 1'b0;
         d.clash = 1'b0;
      end
      // [R17] vector fetch clears done
      if (i_irq_vector_ack) begin
         d.done = 1'b0;
      end

      if (acc & i_avs_write) begin
         case (i_avs_address)
            SPIMSP_OFS_CTRL: d.ctrl = i_avs_writedata[7:0];
            SPIMSP_OFS_STAT: d.dbl  = i_avs_writedata[SPIMSP_S_DBL];
            SPIMSP_OFS_DATA: begin
               if (busy) begin
                  // [R18] [R26] flag only, byte untouched
                  d.clash = 1'b1;
               end else begin
                  // [R22] [R24] load and start
                  d.shreg = i_avs_writedata[7:0];
                  d.tx    = out_bit(lsbf, i_avs_writedata[7:0]);
                  if (en & master_select_bit) begin
                     d.state    = SPIMSP_XFER;
                     d.divcnt   = 7'h00;
                     d.edge_idx = 4'h0;
                     d.bitcnt   = 4'h0;
                  end
               end
            end
            default: d.ctrl = q.ctrl;
         endcase
      end

      case (q.state)
         SPIMSP_IDLE: begin
            // [R9] SCK rests at idle level
            d.sck = clock_idle_level;
         end
         SPIMSP_XFER: begin
            if (q.divcnt == half - 7'h01) begin
               d.divcnt   = 7'h00;
               d.sck      = ~q.sck;
               d.edge_idx = q.edge_idx + 4'h1;
               if (q.edge_idx[0] == clock_sample_phase) begin
                  // [R7] master samples MISO
                  d.shreg  = shift_in(lsbf, q.shreg, i_miso_i);
                  d.bitcnt = q.bitcnt + 4'h1;
                  if (q.bitcnt == SPIMSP_BYTE_CNT - 4'h1) begin
                     // [R24] receive buffer overwritten
                     d.rxbuf = shift_in(lsbf, q.shreg, i_miso_i);
                  end
               end else begin
                  d.tx = out_bit(lsbf, q.shreg);
               end
               // [R23] stop after sixteen edges
               if (q.edge_idx == SPIMSP_LAST_EDGE) begin
                  d.state  = SPIMSP_IDLE;
                  d.bitcnt = 4'h0;
                  // [R16] byte complete
                  d.done   = 1'b1;
               end
            end else begin
               d.divcnt = q.divcnt + 7'h01;
            end
         end
         default: d.state = SPIMSP_IDLE;
      endcase

      // [R15] slave logic ignores rate bits
      if (slave_on) begin
         if (s_sample) begin
            d.shreg  = shift_in(lsbf, q.shreg, i_mosi_i);
            d.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt == SPIMSP_BYTE_CNT - 4'h1) begin
               d.rxbuf  = shift_in(lsbf, q.shreg, i_mosi_i);
               d.bitcnt = 4'h0;
               // [R16] slave byte complete
               d.done   = 1'b1;
            end
         end else if (s_setup) begin
            d.tx = out_bit(lsbf, q.shreg);
         end else if ((q.bitcnt == 4'h0) & ~clock_sample_phase) begin
            // First bit must already stand before the leading edge
            d.tx = out_bit(lsbf, q.shreg);
         end
      end else if (~master_select_bit) begin
         // [R2] select high drops partial byte
         d.bitcnt = 4'h0;
      end

      if (mode_fault) begin
         // [R4] demote to slave
         d.ctrl[SPIMSP_C_MASTER_SELECT_BIT] = 1'b0;
         d.state  = SPIMSP_IDLE;
         d.bitcnt = 4'h0;
         d.sck    = clock_idle_level;
         // [R5] fault sets done
         d.done   = 1'b1;
      end

      // [R12] disabled port does nothing
      if (~en) begin
         d.state  = SPIMSP_IDLE;
         d.bitcnt = 4'h0;
         d.sck    = clock_idle_level;
      end

      // [R1] [R4] pin directions
      d.sck_oe  = en & master_select_bit & ~mode_fault & i_sck_dir;
      d.mosi_oe = en & master_select_bit & ~mode_fault & i_mosi_dir;
      d.miso_oe = slave_on & i_miso_dir;
      // [R3] select as general output in master
      d.ss_o    = i_ss_gpo;
      d.ss_oe   = i_ss_dir & ~(en & ~master_select_bit);
      // [R13] interrupt request
      d.irq     = d.done & d.ctrl[SPIMSP_C_IRQEN] & i_global_irq_en;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q          <= '0;
         q.waitreq  <= 1'b1;
         q.ctrl     <= SPIMSP_CTRL_RST;
         q.shreg    <= SPIMSP_DATA_RST;
         q.rxbuf    <= SPIMSP_DATA_RST;
         q.state    <= SPIMSP_IDLE;
      end else begin
         q <= d;
      end
   end

   assign o_avs_readdata    = q.rdata;
   assign o_avs_waitrequest = q.waitreq;
   assign o_irq             = q.irq;
   assign o_sck_o           = q.sck;
   assign o_sck_oe          = q.sck_oe;
   assign o_mosi_o          = q.tx;
   assign o_mosi_oe         = q.mosi_oe;
   assign o_miso_o          = q.tx;
   assign o_miso_oe         = q.miso_oe;
   assign o_ss_o            = q.ss_o;
   assign o_ss_oe           = q.ss_oe;

endmodule // spimsp_top

//--- sim/spimsp_asserts.sv
`timescale 1ns/100ps
module spimsp_asserts
   import spimsp_pkg::*;
(
   // Clock, reset and bus
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic [3:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   // Pins and interrupt
   input wire logic        i_sck_dir,
   input wire logic        i_miso_dir,
   input wire logic        i_ss_dir,
   input wire logic        i_ss_gpo,
   input wire logic        i_ss_i,
   input wire logic        i_global_irq_en,
   input wire logic        i_irq_vector_ack,
   input wire logic        o_irq,
   input wire logic        o_sck_oe,
   input wire logic        o_miso_oe,
   input wire logic        o_ss_o,
   input wire logic        o_ss_oe
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_answer;
      !o_avs_waitrequest;
   endsequence
   sequence s_stat_read;
      $past(i_avs_read) && $past(i_avs_address) == SPIMSP_OFS_STAT;
   endsequence
   // Another master pulls select low while we drive the clock
   sequence s_fault;
      o_sck_oe && !i_ss_dir && !i_ss_i;
   endsequence

   wait_once_a: assert property (
      s_answer |=> o_avs_waitrequest) else $error("answer held too long");
   reserved_zero_a: assert property (
      (s_answer and s_stat_read) |-> o_avs_readdata[5:1] == 5'h00)
      else $error("reserved status bits set");
   irq_global_a: assert property (
      o_irq |-> $past(i_global_irq_en)) else $error("irq without enable");
   vector_clear_a: assert property (
      i_irq_vector_ack |-> ##[1:2] !o_irq) else $error("irq not cleared");
   miso_slave_a: assert property (
      o_miso_oe |-> $past(i_miso_dir) && !$past(i_ss_i))
      else $error("miso driven while not selected");
   sck_dir_a: assert property (
      o_sck_oe |-> $past(i_sck_dir)) else $error("sck driven as input");
   select_out_a: assert property (
      o_ss_oe |-> $past(i_ss_dir) && o_ss_o == $past(i_ss_gpo))
      else $error("select output wrong");
   fault_demote_a: assert property (
      s_fault |-> ##[1:3] !o_sck_oe) else $error("no demotion to slave");
endmodule // spimsp_asserts

bind spimsp_top spimsp_asserts chk_i (.*);

//--- sim/spimsp_peer.sv
`timescale 1ns/100ps
module spimsp_peer (
   // Wire side
   input  wire logic       i_sck,
   input  wire logic       i_mosi,
   input  wire logic       i_sel_n,
   output logic            o_miso,
   // Mode and data
   input  wire logic       i_clock_idle_level,
   input  wire logic       i_clock_sample_phase,
   input  wire logic       i_lsbf,
   input  wire logic [7:0] i_tx,
   output logic      [7:0] o_rx
);
   int   sets = 0;
   int   k;
   logic last = 1'h0;
   always @(negedge i_sel_n) sets = 0;
   // sample and setup on opposite edges
   always @(i_sck) begin
      if (!i_sel_n && ((i_sck != i_clock_idle_level) ^ i_clock_sample_phase))
         o_rx = i_lsbf ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
      else if (!i_sel_n)
         sets++;
   end
   // bit order; released line shows the inverse, not a held value
   always @* begin
      k = (i_clock_sample_phase && sets > 0) ? sets - 1 : sets;
      k = (k > 7) ? 7 : k;
      o_miso = i_sel_n ? ~last : i_tx[i_lsbf ? k : 7 - k];
   end
   always @(o_miso) if (!i_sel_n) last = o_miso;
endmodule // spimsp_peer

//--- sim/spimsp_bench.sv
`timescale 1ns/100ps
module spimsp_bench
   import spimsp_pkg::*;
;
   typedef struct packed {
      logic [7:0] c;
      logic       d;
      logic [7:0] t;
      logic [7:0] p;
   } spimsp_row_s;
   localparam spimsp_row_s ROWS [6] = '{
      '{8'hD0, 1'h0, 8'hA5, 8'h3C}, '{8'h55, 1'h0, 8'h81, 8'h7E},
      '{8'h7A, 1'h1, 8'h1E, 8'hB4}, '{8'hDF, 1'h0, 8'h6D, 8'h29},
      '{8'h7C, 1'h1, 8'h01, 8'h80}, '{8'hF3, 1'h1, 8'hC8, 8'h13}};
   // Half SCK period in clocks, indexed by double rate and rate bits
   localparam int HALF [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
   // Byte the bench sends when it acts as the external master
   localparam logic [7:0] SLV_RX = 8'h5C;
   logic        i_core_clk = 1'h0, i_rst_n = 1'h0;
   logic        i_avs_read = 1'h0, i_avs_write = 1'h0;
   logic [3:0]  i_avs_address = 4'h0;
   logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
   logic        i_sck_dir = 1'h1, i_mosi_dir = 1'h1, i_miso_dir = 1'h0;
   logic        i_ss_dir = 1'h1, i_ss_gpo = 1'h1, ss_ext = 1'h1;
   logic        i_global_irq_en = 1'h1, i_irq_vector_ack = 1'h0;
   logic        o_avs_waitrequest, o_irq, o_sck_o, o_sck_oe, o_mosi_o;
   logic        o_mosi_oe, o_miso_o, o_miso_oe, o_ss_o, o_ss_oe, peer_miso;
   logic        pcpol = 1'h0, pcpha = 1'h0, plsb = 1'h0, ps = 1'h0;
   logic        ext_sck = 1'h0, ext_mosi = 1'h0;
   logic [7:0]  ptx = 8'h00, prx;
   int          cnt = 0, gap = 0, checks = 0, error_cnt = 0;
   wire         i_sck_i  = o_sck_oe ? o_sck_o : ext_sck;
   wire         i_mosi_i = o_mosi_oe ? o_mosi_o : ext_mosi;
   wire         i_ss_i   = o_ss_oe ? o_ss_o : ss_ext;
   wire         i_miso_i = o_miso_oe ? o_miso_o : peer_miso;

   spimsp_top uut (.*);
   spimsp_peer peer (.i_sck(i_sck_i), .i_mosi(i_mosi_i), .i_sel_n(i_ss_i),
      .o_miso(peer_miso), .i_clock_idle_level(pcpol), .i_clock_sample_phase(pcpha), .i_lsbf(plsb),
      .i_tx(ptx), .o_rx(prx));

   always #10 i_core_clk = ~i_core_clk;
   // Clocks between SCK changes; the last gap is the running half period
   always @(posedge i_core_clk) begin
      cnt++;
      if (o_sck_o !== ps) begin
         gap = cnt;
         cnt = 0;
      end
      ps = o_sck_o;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_of_test;
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge i_core_clk);
      i_avs_write <= w;
      i_avs_read <= !w;
      i_avs_address <= a;
      i_avs_writedata <= {24'h000000, d};
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_avs_waitrequest !== 1'h0 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         end_of_test();
      end
      q = o_avs_readdata[7:0];
      i_avs_write <= 1'h0;
      i_avs_read <= 1'h0;
   endtask
   task automatic start(input spimsp_row_s r);
      logic [7:0] q;
      {pcpol, pcpha, plsb, ptx} = {r.c[3], r.c[2], r.c[5], r.p};
      bus(1'h1, SPIMSP_OFS_CTRL, r.c, q);
      bus(1'h1, SPIMSP_OFS_STAT, {7'h00, r.d}, q);
      i_ss_gpo <= 1'h0;
      bus(1'h1, SPIMSP_OFS_DATA, r.t, q);
   endtask
   // Slowest byte takes 1024 clocks; the bound leaves margin
   task automatic wait_done(output logic [7:0] q);
      int n;
      n = 0;
      do begin
         bus(1'h0, SPIMSP_OFS_STAT, 8'h00, q);
         n++;
      end while (q[7] !== 1'h1 && n < 1000);
      if (n >= 1000) begin
         error_cnt++;
         end_of_test();
      end
   endtask

   initial begin
      logic [7:0] q;
      logic [7:0] sr;
      repeat (3) @(posedge i_core_clk);
      i_rst_n <= 1'h1;
      bus(1'h0, SPIMSP_OFS_CTRL, 8'h00, q);
      chk(q, SPIMSP_CTRL_RST);
      bus(1'h0, 4'hC, 8'h00, q);
      chk(q, 8'h00);
      foreach (ROWS[i]) begin
         start(ROWS[i]);
         wait_done(q);
         chk(q, {1'h1, 6'h00, ROWS[i].d});
         chk(o_irq, ROWS[i].c[7]);
         bus(1'h0, SPIMSP_OFS_DATA, 8'h00, q);
         chk(q, ROWS[i].p);
         chk(prx, ROWS[i].t);
         chk(gap, HALF[{ROWS[i].d, ROWS[i].c[1:0]}]);
         i_ss_gpo <= 1'h1;
         bus(1'h0, SPIMSP_OFS_STAT, 8'h00, q);
         chk(q, {7'h00, ROWS[i].d});
      end
      start('{8'h53, 1'h0, 8'h5A, 8'hE7});
      bus(1'h1, SPIMSP_OFS_DATA, 8'h00, q);
      wait_done(q);
      chk(q, 8'hC0);
      bus(1'h0, SPIMSP_OFS_DATA, 8'h00, q);
      chk(q, 8'hE7);
      chk(prx, 8'h5A);
      bus(1'h0, SPIMSP_OFS_STAT, 8'h00, q);
      chk(q, 8'h00);
      start('{8'hD0, 1'h0, 8'h11, 8'h22});
      wait_done(q);
      i_irq_vector_ack <= 1'h1;
      @(posedge i_core_clk);
      i_irq_vector_ack <= 1'h0;
      bus(1'h0, SPIMSP_OFS_STAT, 8'h00, q);
      chk(q, 8'h00);
      chk(o_irq, 1'h0);
      i_ss_gpo <= 1'h1;
      bus(1'h1, SPIMSP_OFS_CTRL, 8'h10, q);
      bus(1'h1, SPIMSP_OFS_DATA, 8'h77, q);
      repeat (20) bus(1'h0, SPIMSP_OFS_STAT, 8'h00, q);
      chk(q, 8'h00);
      bus(1'h1, SPIMSP_OFS_CTRL, 8'hD0, q);
      i_ss_dir <= 1'h0;
      ss_ext <= 1'h0;
      // Select reaches the pin a cycle late, the demotion one more
      repeat (2) @(posedge i_core_clk);
      bus(1'h0, SPIMSP_OFS_CTRL, 8'h00, q);
      chk(q[4], 1'h0);
      bus(1'h0, SPIMSP_OFS_STAT, 8'h00, q);
      chk(q[7], 1'h1);
      chk(o_irq, 1'h1);
      chk(o_sck_oe, 1'h0);
      i_miso_dir <= 1'h1;
      repeat (2) @(posedge i_core_clk);
      chk(o_miso_oe, 1'h1);
      ss_ext <= 1'h1;
      repeat (2) @(posedge i_core_clk);
      chk(o_miso_oe, 1'h0);
      // bench acts as external master, three clocks per SCK phase
      bus(1'h1, SPIMSP_OFS_DATA, 8'hA3, q);
      ss_ext <= 1'h0;
      sr = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         ext_mosi <= SLV_RX[b];
         repeat (3) @(posedge i_core_clk);
         sr = {sr[6:0], i_miso_i};
         ext_sck <= 1'h1;
         repeat (3) @(posedge i_core_clk);
         ext_sck <= 1'h0;
      end
      repeat (3) @(posedge i_core_clk);
      ss_ext <= 1'h1;
      chk(sr, 8'hA3);
      bus(1'h0, SPIMSP_OFS_STAT, 8'h00, q);
      chk(q, 8'h80);
      bus(1'h0, SPIMSP_OFS_DATA, 8'h00, q);
      chk(q, SLV_RX);
      // software sets the master bit again after demotion
      bus(1'h1, SPIMSP_OFS_CTRL, 8'hD0, q);
      bus(1'h0, SPIMSP_OFS_CTRL, 8'h00, q);
      chk(q, 8'hD0);
      end_of_test();
   end
endmodule // spimsp_bench
